// ===== core/fsr_core.sv
// Purpose: serial flash identity read-out and program/erase suspend
// Assumes: array engine on clk_sys; host link clocked by spi_clk
// Notes: spi_clk stops between frames; frame count, shift and read mode end with select, the event word and toggle do not
`timescale 1ns/1ps
`include "fsr_params.svh"

module fsr_core
	import fsr_pkg::*;
#(
	parameter logic [7:0] ID_MAKER = `FSR_ID_MAKER,
	parameter logic [7:0] ID_TYPE = `FSR_ID_TYPE,
	parameter logic [7:0] ID_CAP = `FSR_ID_CAP,
	parameter logic [127:0] UNIQUE_ID = `FSR_UID_VAL
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic ce,
	input wire logic spi_clk,
	input wire logic cs_n,
	input wire logic si,
	output logic spi_so,
	output logic spi_so_oe,
	input wire logic op_start,
	input wire fsr_kind_t op_kind,
	input wire logic [23:0] op_addr,
	input wire logic op_done,
	input wire logic [23:0] prot_floor,
	output fsr_stat_t status,
	output logic array_hold,
	output logic prog_go,
	output logic [23:0] prog_addr,
	output logic fence_on,
	output logic [23:0] fence_base,
	output logic [23:0] fence_mask
);

	// ****************************************************************
	// decoding helpers
	// ****************************************************************
	localparam int PSL_CYC = (`FSR_T_PSL_NS + `FSR_CLK_NS - 1) / `FSR_CLK_NS;
	localparam int ESL_CYC = (`FSR_T_ESL_NS + `FSR_CLK_NS - 1) / `FSR_CLK_NS;

	function automatic logic f_sus(input logic [7:0] op);
		return op == `FSR_OP_SUS_A || op == `FSR_OP_SUS_B;
	endfunction

	function automatic logic f_res(input logic [7:0] op);
		return op == `FSR_OP_RES_A || op == `FSR_OP_RES_B;
	endfunction

	function automatic logic f_prog(input logic [7:0] op);
		return op == `FSR_OP_PROG1 || op == `FSR_OP_PROG2 ||
			op == `FSR_OP_PROG4;
	endfunction

	function automatic logic f_evop(input logic [7:0] op);
		return f_sus(op) || f_res(op) || op == `FSR_OP_LATCH_SET ||
			op == `FSR_OP_LATCH_CLR;
	endfunction

	function automatic logic [23:0] f_mask(input fsr_kind_t k);
		unique case (k)
		K_PAGE_PROG, K_PAGE_ERASE: return `FSR_MASK_PAGE;
		K_SECTOR: return `FSR_MASK_SECT;
		K_HALF: return `FSR_MASK_HALF;
		K_BLOCK: return `FSR_MASK_BLOCK;
		default: return `FSR_MASK_BLOCK;
		endcase
	endfunction

	// ****************************************************************
	// link side, clocked by spi_clk
	// ****************************************************************
	logic link_rst;
	logic [7:0] cnt_r;
	logic [7:0] cnt_nxt;
	logic [23:0] sh_r;
	logic [23:0] sh_nxt;
	logic [7:0] op_nxt;
	logic [7:0] op_r;
	fsr_mode_t mode_r;
	fsr_mode_t mode_nxt;
	fsr_ev_t ev_r;
	logic tog_r;
	logic send_op;
	logic send_prog;
	logic [1:0] lk_s;
	logic [7:0] id_idx;
	logic [7:0] uid_idx;
	logic in_id;
	logic in_uid;
	logic out_bit;
	logic [23:0] id_word;
	logic so_r;
	logic so_oe_r;

	// select high clears the frame at once, even with the clock stopped
	assign link_rst = cs_n | ~resetn;
	assign cnt_nxt = (cnt_r == 8'hFF) ? cnt_r : cnt_r + 8'h01;
	assign sh_nxt = {sh_r[22:0], si};
	assign op_nxt = sh_nxt[7:0];
	assign id_word = {ID_MAKER, ID_TYPE, ID_CAP};

	// busy or waiting out latency: identity not decoded
	assign mode_nxt = (op_nxt == `FSR_OP_ID && !lk_s[1]) ? M_ID :
		(op_nxt == `FSR_OP_UID && lk_s == 2'h0) ? M_UID :
		M_NONE;

	assign send_op = cnt_r == `FSR_OPC_LAST && f_evop(op_nxt);
	assign send_prog = cnt_r == `FSR_ADR_LAST && f_prog(op_r);

	always_ff @(posedge spi_clk or posedge link_rst) begin
		if (link_rst) begin
			cnt_r <= 8'h00;
			sh_r <= 24'h000000;
			mode_r <= M_NONE;
		end else begin
			cnt_r <= cnt_nxt;
			sh_r <= sh_nxt;
			if (cnt_r == `FSR_OPC_LAST) begin
				mode_r <= mode_nxt;
			end
		end
	end

	// event word stays put until the next event or program command, well past the sync
	always_ff @(posedge spi_clk or negedge resetn) begin
		if (!resetn) begin
			op_r <= 8'h00;
			ev_r <= 32'h00000000;
			tog_r <= 1'b0;
		end else if (!cs_n) begin
			if (cnt_r == `FSR_OPC_LAST) begin
				op_r <= op_nxt;
			end
			if (send_op) begin
				ev_r <= {op_nxt, 24'h000000};
				tog_r <= ~tog_r;
			end else if (send_prog) begin
				ev_r <= {op_r, sh_nxt};
				tog_r <= ~tog_r;
			end
		end
	end

	assign id_idx = cnt_r - `FSR_ID_FIRST;
	assign uid_idx = cnt_r - `FSR_UID_FIRST;
	assign in_id = mode_r == M_ID && cnt_r >= `FSR_ID_FIRST &&
		cnt_r < `FSR_ID_END;
	assign in_uid = mode_r == M_UID && cnt_r >= `FSR_UID_FIRST &&
		cnt_r < `FSR_UID_END;
	assign out_bit = in_id ? id_word[5'h17 - id_idx[4:0]] :
		in_uid ? UNIQUE_ID[7'h7F - uid_idx[6:0]] : 1'b0;

	always_ff @(negedge spi_clk or posedge link_rst) begin
		if (link_rst) begin
			so_r <= 1'b0;
			so_oe_r <= 1'b0;
		end else begin
			so_r <= out_bit;
			so_oe_r <= in_id | in_uid;
		end
	end

	assign spi_so = so_r;
	assign spi_so_oe = so_oe_r;

	// ****************************************************************
	// array-side sequencer, clocked by clk_sys
	// ****************************************************************
	fsr_state_t state_r;
	fsr_state_t state_nxt;
	fsr_stat_t stat_r;
	fsr_stat_t stat_nxt;
	fsr_kind_t kind_r;
	logic [15:0] lat_r;
	logic [15:0] lat_nxt;
	logic [15:0] lat_init;
	logic tog_s;
	logic tog_d_r;
	logic ev_hit;
	logic is_erase;
	logic prog_ok;
	logic go_nxt;
	logic go_r;
	logic [23:0] go_addr_r;
	logic lock_r;
	logic susp_r;
	logic hold_r;
	logic [23:0] fbase_r;
	logic [23:0] fmask_r;

	fsr_sync #(.W(1)) u_tog_sync (
		.clk(clk_sys),
		.rst_n(resetn),
		.en(ce),
		.d(tog_r),
		.q(tog_s)
	);

	fsr_sync #(.W(2)) u_lock_sync (
		.clk(spi_clk),
		.rst_n(resetn),
		.en(1'b1),
		.d({lock_r, susp_r}),
		.q(lk_s)
	);

	assign ev_hit = tog_s ^ tog_d_r;
	assign is_erase = kind_r != K_PAGE_PROG;
	assign lat_init = (kind_r == K_PAGE_PROG) ? 16'(PSL_CYC) : 16'(ESL_CYC);
	assign prog_ok = is_erase && stat_r.write_enable_latch &&
		(ev_r.addr & ~fmask_r) != fbase_r &&
		ev_r.addr < prot_floor;

	always_comb begin
		state_nxt = state_r;
		stat_nxt = stat_r;
		lat_nxt = lat_r;
		go_nxt = 1'b0;
		unique case (state_r)
		ST_IDLE: begin
			if (op_start) begin
				state_nxt = ST_RUN;
				stat_nxt.write_in_progress = 1'b1;
			end else if (ev_hit && ev_r.op == `FSR_OP_LATCH_SET) begin
				stat_nxt.write_enable_latch = 1'b1;
			end else if (ev_hit && ev_r.op == `FSR_OP_LATCH_CLR) begin
				stat_nxt.write_enable_latch = 1'b0;
			end
		end
		ST_RUN: begin
			if (op_done) begin
				state_nxt = ST_IDLE;
				stat_nxt = `FSR_STAT_RST;
			end else if (ev_hit && f_sus(ev_r.op)) begin
				state_nxt = ST_WAIT;
				lat_nxt = lat_init;
			end
		end
		ST_WAIT: begin
			if (op_done) begin
				state_nxt = ST_IDLE;
				stat_nxt = `FSR_STAT_RST;
			end else begin
				if (ev_hit && ev_r.op == `FSR_OP_LATCH_CLR) begin
					stat_nxt.write_enable_latch = 1'b0;
				end
				if (lat_r <= 16'h0001) begin
					state_nxt = ST_SUSP;
					stat_nxt.write_enable_latch = 1'b0;
					stat_nxt.write_in_progress = 1'b0;
					stat_nxt.program_suspended_flag = !is_erase;
					stat_nxt.erase_suspended_flag = is_erase;
				end else begin
					lat_nxt = lat_r - 16'h0001;
				end
			end
		end
		ST_SUSP: begin
			if (ev_hit && f_res(ev_r.op)) begin
				state_nxt = ST_RUN;
				stat_nxt.write_enable_latch = 1'b1;
				stat_nxt.write_in_progress = 1'b1;
				stat_nxt.program_suspended_flag = 1'b0;
				stat_nxt.erase_suspended_flag = 1'b0;
			end else if (ev_hit && ev_r.op == `FSR_OP_LATCH_CLR) begin
				stat_nxt.write_enable_latch = 1'b0;
			end else if (ev_hit && ev_r.op == `FSR_OP_LATCH_SET &&
				is_erase) begin
				stat_nxt.write_enable_latch = 1'b1;
			end else if (ev_hit && f_prog(ev_r.op) && prog_ok) begin
				state_nxt = ST_SPROG;
				stat_nxt.write_in_progress = 1'b1;
				go_nxt = 1'b1;
			end
		end
		ST_SPROG: begin
			// suspend and resume both fall on the floor here
			if (op_done) begin
				state_nxt = ST_SUSP;
				stat_nxt.write_enable_latch = 1'b0;
				stat_nxt.write_in_progress = 1'b0;
			end
		end
		default: begin
			state_nxt = ST_IDLE;
		end
		endcase
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state_r <= ST_IDLE;
			stat_r <= `FSR_STAT_RST;
			lat_r <= 16'h0000;
			tog_d_r <= 1'b0;
			go_r <= 1'b0;
		end else if (ce) begin
			state_r <= state_nxt;
			stat_r <= stat_nxt;
			lat_r <= lat_nxt;
			tog_d_r <= tog_s;
			go_r <= go_nxt;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			kind_r <= K_PAGE_PROG;
			fbase_r <= 24'h000000;
			fmask_r <= 24'h000000;
			go_addr_r <= 24'h000000;
			lock_r <= 1'b0;
			susp_r <= 1'b0;
			hold_r <= 1'b0;
		end else if (ce) begin
			if (state_r == ST_IDLE && op_start) begin
				kind_r <= op_kind;
				fbase_r <= op_addr & ~f_mask(op_kind);
				fmask_r <= f_mask(op_kind);
			end
			if (go_nxt) begin
				go_addr_r <= ev_r.addr;
			end
			lock_r <= state_nxt inside {ST_RUN, ST_WAIT, ST_SPROG};
			// busy or suspended: identity read checks the lock bit alone, unique read needs both bits low,
			// so skew between the two bits never opens a false window
			susp_r <= state_nxt != ST_IDLE;
			hold_r <= state_nxt inside {ST_WAIT, ST_SUSP, ST_SPROG};
		end
	end

	// fence stays on through a program inside the suspended erase
	assign status = stat_r;
	assign array_hold = hold_r;
	assign prog_go = go_r;
	assign prog_addr = go_addr_r;
	assign fence_on = hold_r;
	assign fence_base = fbase_r;
	assign fence_mask = fmask_r;

	// ****************************************************************
	// checks
	// ****************************************************************
	chk_resume_bits: assert property (@(posedge clk_sys) disable iff (!resetn)
		(ce && state_r == ST_SUSP && ev_hit && f_res(ev_r.op)) |=>
		(state_r == ST_RUN && stat_r.write_enable_latch &&
		stat_r.write_in_progress && !stat_r.program_suspended_flag &&
		!stat_r.erase_suspended_flag))
		else $error("resume did not restore latch and busy");

	chk_wait_no_flag: assert property (@(posedge clk_sys) disable iff (!resetn)
		(state_r == ST_WAIT) |->
		!(stat_r.program_suspended_flag || stat_r.erase_suspended_flag))
		else $error("suspend flag set before latency");

	chk_latency_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
		(state_r == ST_WAIT && lat_r > 16'h0001) |=> state_r != ST_SUSP)
		else $error("suspend taken before latency elapsed");

	chk_flag_latch: assert property (@(posedge clk_sys) disable iff (!resetn)
		$rose(stat_r.program_suspended_flag || stat_r.erase_suspended_flag)
		|-> (!stat_r.write_enable_latch && state_r == ST_SUSP))
		else $error("latch not cleared on suspend");

	chk_flag_kind: assert property (@(posedge clk_sys) disable iff (!resetn)
		(stat_r.program_suspended_flag || stat_r.erase_suspended_flag) |->
		(stat_r.program_suspended_flag == (kind_r == K_PAGE_PROG)))
		else $error("wrong suspend flag for operation kind");

	chk_sprog_bits: assert property (@(posedge clk_sys) disable iff (!resetn)
		(state_r == ST_SPROG) |->
		(stat_r.write_enable_latch && stat_r.write_in_progress))
		else $error("latch or busy low during suspended program");

	chk_sprog_stays: assert property (@(posedge clk_sys) disable iff (!resetn)
		(ce && state_r == ST_SPROG && !op_done) |=> state_r == ST_SPROG)
		else $error("program inside erase suspend interrupted");

	chk_prog_fence: assert property (@(posedge clk_sys) disable iff (!resetn)
		prog_go |-> ((prog_addr & ~fmask_r) != fbase_r &&
		kind_r != K_PAGE_PROG && $past(stat_r.write_enable_latch)))
		else $error("program started inside suspended region");

	chk_id_lock: assert property (@(posedge spi_clk) disable iff (link_rst)
		(cnt_r == `FSR_OPC_LAST && lk_s[1]) |=> mode_r == M_NONE)
		else $error("identity decoded while busy");

	chk_quiet_out: assert property (@(posedge spi_clk) disable iff (link_rst)
		(mode_r == M_NONE) |-> !so_oe_r)
		else $error("output driven without a read");

	cov_erase_susp: cover property (@(posedge clk_sys) disable iff (!resetn)
		$rose(stat_r.erase_suspended_flag));
	cov_sprog: cover property (@(posedge clk_sys) disable iff (!resetn)
		state_r == ST_SPROG ##1 state_r == ST_SUSP);
	cov_resume: cover property (@(posedge clk_sys) disable iff (!resetn)
		state_r == ST_SUSP ##1 state_r == ST_RUN);
	cov_id_read: cover property (@(posedge spi_clk) disable iff (link_rst)
		in_id && cnt_r == 8'h1F);

endmodule // fsr_core

// ===== core/fsr_params.svh
// Purpose: constants of the flash suspend/resume and identity block
// Assumes: included by bare name wherever needed
// Notes: definitions only
`ifndef FSR_PARAMS_SVH
`define FSR_PARAMS_SVH

// ****************************************************************
// opcodes
// ****************************************************************
`define FSR_OP_ID 8'h9F
`define FSR_OP_UID 8'h4B
`define FSR_OP_SUS_A 8'h75
`define FSR_OP_SUS_B 8'hB0
`define FSR_OP_RES_A 8'h7A
`define FSR_OP_RES_B 8'h30
`define FSR_OP_LATCH_SET 8'h06
`define FSR_OP_LATCH_CLR 8'h04
`define FSR_OP_PROG1 8'h02
`define FSR_OP_PROG2 8'hA2
`define FSR_OP_PROG4 8'h32

// ****************************************************************
// frame positions, in rising edges since select
// ****************************************************************
`define FSR_OPC_LAST 8'h07
`define FSR_ADR_LAST 8'h1F
`define FSR_ID_FIRST 8'h08
`define FSR_ID_END 8'h20
`define FSR_UID_FIRST 8'h28
`define FSR_UID_END 8'hA8

// ****************************************************************
// identity defaults, all values arbitrary
// ****************************************************************
`define FSR_ID_MAKER 8'h5A
`define FSR_ID_TYPE 8'h40
`define FSR_ID_CAP 8'h16
`define FSR_UID_VAL 128'h0123456789ABCDEF_FEDCBA9876543210

// ****************************************************************
// protected regions per operation kind, reset values, timing
// ****************************************************************
`define FSR_MASK_PAGE 24'h0000FF
`define FSR_MASK_SECT 24'h000FFF
`define FSR_MASK_HALF 24'h007FFF
`define FSR_MASK_BLOCK 24'h00FFFF
`define FSR_STAT_RST 4'h0
`define FSR_CLK_NS 100
`define FSR_T_PSL_NS 20000
`define FSR_T_ESL_NS 20000

`endif

// ===== core/fsr_pkg.sv
// Purpose: types of the flash suspend/resume and identity block
// Assumes: nothing
// Notes: constants live in fsr_params.svh
package fsr_pkg;

	typedef enum logic [2:0] {
		K_PAGE_PROG,
		K_PAGE_ERASE,
		K_SECTOR,
		K_HALF,
		K_BLOCK
	} fsr_kind_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RUN,
		ST_WAIT,
		ST_SUSP,
		ST_SPROG
	} fsr_state_t;

	typedef enum logic [1:0] {
		M_NONE,
		M_ID,
		M_UID
	} fsr_mode_t;

	typedef struct packed {
		logic write_enable_latch;
		logic write_in_progress;
		logic program_suspended_flag;
		logic erase_suspended_flag;
	} fsr_stat_t;

	typedef struct packed {
		logic [7:0] op;
		logic [23:0] addr;
	} fsr_ev_t;

endpackage

// ===== core/fsr_sync.sv
// Purpose: two-flop level synchroniser
// Assumes: input is quasi-static against the receiving clock
// Notes: first stage is read only by the second
`timescale 1ns/1ps
module fsr_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic en,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_r;
	logic [W-1:0] hold_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= '0;
			hold_r <= '0;
		end else if (en) begin
			meta_r <= d;
			hold_r <= meta_r;
		end
	end

	assign q = hold_r;

endmodule // fsr_sync

// ===== dv/fsr_host.sv
// Purpose: host serial controller model driving select, clock and data
// Assumes: clock idles low and stands still between frames
// Notes: one frame per xfer call; phase unrelated to clk_sys
`timescale 1ns/1ps
module fsr_host (
	output logic spi_clk,
	output logic cs_n,
	output logic si,
	input wire logic spi_so,
	input wire logic spi_so_oe
);
	// ****************************************************************
	// frame engine
	// ****************************************************************
	initial begin
		spi_clk = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end

	// never sends power-down, so identity reads are legal whenever the array is not busy
	task automatic xfer(input logic [39:0] tx, input int ntx, input int nrx,
		output logic [127:0] rx, output int oe_cnt);
		rx = '0;
		oe_cnt = 0;
		#37 cs_n = 1'b0;
		for (int i = 0; i < ntx + nrx; i++) begin
			// data moves while clock is low; after the sent bits the line toggles each clock
			si = (i < ntx) ? tx[39 - i] : ~si;
			#80 spi_clk = 1'b1;
			if (i >= ntx) begin
				rx = {rx[126:0], spi_so};
				if (spi_so_oe === 1'b1) oe_cnt++;
			end
			#80 spi_clk = 1'b0;
		end
		#80 cs_n = 1'b1;
		// deselected: no stale level left on the data line
		si = ~si;
	endtask
endmodule // fsr_host

// ===== dv/test_fsr_core.sv
// Purpose: self-checking bench for fsr_core
// Assumes: 10 MHz clk_sys, 160 ns link clock from fsr_host
// Notes: suspend latency is the full 200-cycle default
`timescale 1ns/1ps
`include "fsr_params.svh"
module test_fsr_core
	import fsr_pkg::*;
;
	// ****************************************************************
	// harness
	// ****************************************************************
	logic clk_sys, resetn, ce, op_start, op_done, spi_clk, cs_n, si;
	logic spi_so, spi_so_oe, array_hold, prog_go, fence_on;
	fsr_kind_t op_kind;
	logic [23:0] op_addr, prot_floor, prog_addr, fence_base, fence_mask;
	fsr_stat_t status;
	logic [127:0] rx;
	int oe_cnt, n;
	int fails = 0;
	int total_checks = 0;
	int cyc = 0;
	int go_cnt = 0;

	fsr_host fsr_host_i (.spi_clk(spi_clk), .cs_n(cs_n), .si(si),
		.spi_so(spi_so), .spi_so_oe(spi_so_oe));
	fsr_core fsr_core_i (.clk_sys(clk_sys), .resetn(resetn), .ce(ce),
		.spi_clk(spi_clk), .cs_n(cs_n), .si(si), .spi_so(spi_so),
		.spi_so_oe(spi_so_oe), .op_start(op_start), .op_kind(op_kind),
		.op_addr(op_addr), .op_done(op_done), .prot_floor(prot_floor),
		.status(status), .array_hold(array_hold), .prog_go(prog_go),
		.prog_addr(prog_addr), .fence_on(fence_on),
		.fence_base(fence_base), .fence_mask(fence_mask));

	always #50 clk_sys = ~clk_sys;

	// one place counts program starts and cuts a hang short
	always @(posedge clk_sys) begin
		cyc++;
		if (prog_go === 1'b1) go_cnt++;
		if (cyc == 20000) begin
			fails++;
			$display("FAIL %0t timeout", $time);
			tally_and_finish();
		end
	end

	task tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task chk(input logic [127:0] got, input logic [127:0] exp, string msg);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("FAIL %0t %s got %0h exp %0h", $time, msg, got, exp);
		end
	endtask

	// ****************************************************************
	// shared steps
	// ****************************************************************
	// margin over the 3-4 edge sync delay
	task settle();
		repeat (6) @(posedge clk_sys);
		#1;
	endtask

	task cmd(input logic [7:0] op, input logic [23:0] a = 24'h000000);
		fsr_host_i.xfer({op, a, 8'h00}, (op == 8'h02) ? 32 : 8, 0, rx, oe_cnt);
		settle();
	endtask

	task id_read(input int nrx);
		fsr_host_i.xfer({8'h9F, 32'h00000000}, 8, nrx, rx, oe_cnt);
	endtask

	task pulse_op(input logic done, input fsr_kind_t k, input logic [23:0] a);
		@(posedge clk_sys);
		op_start <= ~done;
		op_done <= done;
		op_kind <= k;
		op_addr <= a;
		@(posedge clk_sys);
		op_start <= 1'b0;
		op_done <= 1'b0;
		settle();
	endtask

	task sus(input logic [7:0] op, input fsr_stat_t exp);
		cmd(op);
		chk(array_hold, 1'b1, "hold");
		chk(status[1:0], 2'b00, "early flag");
		n = 0;
		while (status[1:0] == 2'b00 && n < 300) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		chk(n >= 185 && n <= 205, 1'b1, "latency");
		chk(status, exp, "suspended");
	endtask

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task t_ids();
		id_read(24);
		chk(rx[23:0], {`FSR_ID_MAKER, `FSR_ID_TYPE, `FSR_ID_CAP}, "id");
		chk(oe_cnt, 24, "id drive");
		fsr_host_i.xfer({8'h4B, 32'h00000000}, 40, 128, rx, oe_cnt);
		chk(rx, `FSR_UID_VAL, "unique");
		id_read(12);
		#1 chk(spi_so_oe, 1'b0, "abort");
		id_read(24);
		chk(rx[23:0], {`FSR_ID_MAKER, `FSR_ID_TYPE, `FSR_ID_CAP}, "again");
	endtask

	task t_busy();
		pulse_op(1'b0, K_SECTOR, 24'h012345);
		chk(status.write_in_progress, 1'b1, "run");
		id_read(24);
		chk(oe_cnt, 0, "id busy");
		chk(array_hold, 1'b0, "undisturbed");
		// clock enable low: a done pulse must not be taken
		@(posedge clk_sys) ce <= 1'b0;
		pulse_op(1'b1, K_SECTOR, 24'h012345);
		chk(status, 4'b0100, "frozen");
		@(posedge clk_sys) ce <= 1'b1;
		pulse_op(1'b1, K_SECTOR, 24'h012345);
		chk(status, 4'h0, "done");
	endtask

	task t_kinds();
		logic [23:0] m;
		for (int k = 0; k < 5; k++) begin
			m = (k < 2) ? 24'h0000FF : (k == 2) ? 24'h000FFF :
				(k == 3) ? 24'h007FFF : 24'h00FFFF;
			pulse_op(1'b0, fsr_kind_t'(k), 24'h3456AB);
			sus(k[0] ? 8'hB0 : 8'h75, (k == 0) ? 4'b0010 : 4'b0001);
			chk(fence_on, 1'b1, "fence");
			chk({fence_base, fence_mask}, {24'h3456AB & ~m, m}, "region");
			cmd(k[0] ? 8'h30 : 8'h7A);
			chk({array_hold, status}, 5'h0C, "resume");
			pulse_op(1'b1, fsr_kind_t'(k), 24'h3456AB);
			chk(status, 4'h0, "finished");
		end
	endtask

	task t_esp();
		pulse_op(1'b0, K_BLOCK, 24'h050000);
		sus(8'h75, 4'b0001);
		cmd(8'h06);
		chk(status, 4'b1001, "latch set");
		cmd(8'h04);
		chk(status, 4'b0001, "latch clear");
		cmd(8'h06);
		cmd(8'h02, 24'h05F000);
		cmd(8'h06);
		cmd(8'h02, 24'h200000);
		chk(go_cnt, 0, "refused program");
		cmd(8'h06);
		cmd(8'h02, 24'h0A0100);
		chk({go_cnt[3:0], prog_addr}, {4'h1, 24'h0A0100}, "program");
		chk(status, 4'b1101, "programming");
		cmd(8'h75);
		cmd(8'h7A);
		chk({go_cnt[3:0], status}, 8'h1D, "not suspendable");
		pulse_op(1'b1, K_PAGE_PROG, 24'h0A0100);
		chk(status, 4'b0001, "program done");
		id_read(24);
		chk(oe_cnt, 24, "id in suspend");
		fsr_host_i.xfer({8'h4B, 32'h00000000}, 40, 16, rx, oe_cnt);
		chk(oe_cnt, 0, "unique refused");
		cmd(8'h7A);
		chk(status, 4'b1100, "resume erase");
		pulse_op(1'b1, K_BLOCK, 24'h050000);
		chk(status, 4'h0, "erase done");
	endtask

	task t_psp();
		pulse_op(1'b0, K_PAGE_PROG, 24'h001234);
		sus(8'hB0, 4'b0010);
		cmd(8'h06);
		chk(status, 4'b0010, "no latch");
		cmd(8'hC7);
		chk(status, 4'b0010, "unlisted");
		cmd(8'h30);
		chk(status, 4'b1100, "resume");
		repeat (50) @(posedge clk_sys);
		cmd(8'h75);
		chk(array_hold, 1'b1, "suspend again");
		pulse_op(1'b1, K_PAGE_PROG, 24'h001234);
		chk({array_hold, status}, 5'h00, "done in wait");
	endtask

	initial begin
		clk_sys = 1'b0;
		resetn = 1'b0;
		ce = 1'b1;
		op_start = 1'b0;
		op_done = 1'b0;
		op_kind = K_PAGE_PROG;
		op_addr = 24'h000000;
		prot_floor = 24'h100000;
		repeat (10) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (3) @(posedge clk_sys);
		#1 chk(status, `FSR_STAT_RST, "reset");
		t_ids();
		t_busy();
		t_kinds();
		t_esp();
		t_psp();
		tally_and_finish();
	end
endmodule // test_fsr_core
